//--- famr_pkg.sv
// Function
// - b7h enters 4-byte addressing, no write enable
// - report 4-byte entry field 10100001b
// - resets leave 4-byte mode; report exit field
// - soft reset needs 66h then 99h
// - reset instructions decoded in current width
// - reset-support field 010000b, rfu bit one
// - status write only after 06h or 50h enable
// - 50h enables and activates volatile status copy
// - report status write-enable field 1110000b
// - 71h writes config 800003h bit6
`default_nettype none
package famr_pkg;
   localparam logic [7:0]  CMD_EN4B     = 8'hb7;
   localparam logic [7:0]  CMD_RST_EN   = 8'h66;
   localparam logic [7:0]  CMD_RST      = 8'h99;
   localparam logic [7:0]  CMD_WREN     = 8'h06;
   localparam logic [7:0]  CMD_VWREN    = 8'h50;
   localparam logic [7:0]  CMD_WRSR     = 8'h01;
   localparam logic [7:0]  CMD_RDSR     = 8'h05;
   localparam logic [7:0]  CMD_RDCFG    = 8'h65;
   localparam logic [7:0]  CMD_WRCFG    = 8'h71;
   localparam logic [23:0] CFG_ADDR     = 24'h800003;
   localparam int          QUAD_BIT     = 6;
   localparam logic [7:0]  SR_RESET     = 8'h00;
   localparam logic [7:0]  CFG_RESET    = 8'h00;
   // dword 16 image, fields packed high to low
   localparam logic [7:0]  ENTRY_FIELD  = 8'b10100001;
   localparam logic [9:0]  EXIT_FIELD   = 10'b11_1110_0001;
   localparam logic [5:0]  RST_FIELD    = 6'b010000;
   localparam logic        RFU_BIT      = 1'b1;
   localparam logic [6:0]  SRWE_FIELD   = 7'b1110000;
   localparam logic [31:0] DWORD16      = {ENTRY_FIELD, EXIT_FIELD, RST_FIELD,
                                           RFU_BIT, SRWE_FIELD};
   typedef struct packed {
      logic       addr4;
      logic       wel;
      logic       vol_act;
      logic       quad;
      logic [7:0] sr;
   } famr_stat_s;
endpackage
`default_nettype wire

//--- famr_core.sv
`timescale 1ns/1ps
`default_nettype none
module famr_core (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire logic                 en_i,
   input  wire logic                 sck_i,
   input  wire logic                 cs_n_i,
   input  wire logic [3:0]           dq_i,
   input  wire logic                 hw_reset_n_i,
   output logic      [3:0]           dq_o,
   output logic      [3:0]           dq_oe_o,
   output logic      [31:0]          dword16_o,
   output famr_pkg::famr_stat_s      stat_o
);
   import famr_pkg::*;
   ////////////////////////////////////////////////////////////////
   // link side, sck domain: shift one command frame per cs
   logic [47:0] sh_q;
   logic [5:0]  bits_q;
   logic        lane4_q;
   logic [47:0] fr_q;
   logic [5:0]  fbits_q;
   logic [7:0]  sr_rd_q;
   logic [7:0]  rd_sh_q;
   wire         lane4 = lane4_q;
   wire [47:0]  sh_d4 = {sh_q[43:0], dq_i};
   wire [47:0]  sh_d1 = {sh_q[46:0], dq_i[0]};
   wire [5:0]   step  = lane4 ? 6'd4 : 6'd1;
   // width sampled at frame start; a mode change lands next frame
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bits_q <= 6'd0;
         sh_q   <= 48'h0;
      end else begin
         sh_q   <= lane4 ? sh_d4 : sh_d1;
         bits_q <= (bits_q > 6'd44) ? bits_q : bits_q + step;
      end
   end
   // frame end: held until the next cs rise, read only after cs sync
   always_ff @(posedge cs_n_i) begin
      fr_q    <= sh_q;
      fbits_q <= bits_q;
   end
   // lane width fixed at cs fall; sck is idle between frames,
   // so a synchroniser on sck would only settle inside the frame
   always_ff @(negedge cs_n_i) begin
      lane4_q <= stat_o.quad;
   end
   // read data: status shadow loaded after the opcode, then shifted
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i)
         rd_sh_q <= 8'h00;
      else if (bits_q == 6'd8)
         rd_sh_q <= sr_rd_q;
      else if (bits_q > 6'd8)
         rd_sh_q <= {rd_sh_q[6:0], 1'b0};
   end
   always_ff @(posedge sck_i) begin
      sr_rd_q <= stat_o.sr;
   end
   ////////////////////////////////////////////////////////////////
   // system side, clk domain
   logic       cs1_q, cs2_q, cs3_q;
   logic       hr1_q, hr2_q;
   logic [47:0] cf_q;
   logic [5:0]  cb_q;
   logic        rst_arm_q;
   famr_stat_s  st_q, st_d;
   logic [7:0]  nv_sr_q;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         // idle level of cs, so no false frame edge after reset
         cs1_q <= 1'b1;
         cs2_q <= 1'b1;
         cs3_q <= 1'b1;
         hr1_q <= 1'b1;
         hr2_q <= 1'b1;
      end else if (en_i) begin
         cs1_q <= cs_n_i;
         cs2_q <= cs1_q;
         cs3_q <= cs2_q;
         hr1_q <= hw_reset_n_i; hr2_q <= hr1_q;
      end
   end
   function automatic logic op_hit(input logic [7:0] o,
                                   input logic [5:0] n,
                                   input logic [7:0] c);
      return (n == 6'd8) && (o == c);
   endfunction
   wire        fr_ev  = cs2_q && !cs3_q;
   // frame captured at cs rise, long settled once cs is synced
   wire [7:0]  op     = (fbits_q >= 6'd8) ? fr_q[(fbits_q-6'd8) +: 8] : 8'h00;
   wire [7:0]  arg8   = fr_q[7:0];
   wire        is_en4 = fr_ev && op_hit(op, fbits_q, CMD_EN4B);
   wire        is_ren = fr_ev && op_hit(op, fbits_q, CMD_RST_EN);
   wire        is_rst = fr_ev && op_hit(op, fbits_q, CMD_RST) && rst_arm_q;
   wire        is_wen = fr_ev && op_hit(op, fbits_q, CMD_WREN);
   wire        is_ven = fr_ev && op_hit(op, fbits_q, CMD_VWREN);
   wire        is_wsr = fr_ev && fbits_q == 6'd16 && fr_q[15:8] == CMD_WRSR;
   wire        cfg_ok = fr_q[31:8] == CFG_ADDR;
   wire        is_wcf = fr_ev && fbits_q == 6'd40 && fr_q[39:32] == CMD_WRCFG && cfg_ok;
   wire        hw_rst = !hr2_q;
   always_comb begin
      st_d = st_q;
      if (is_en4)
         st_d.addr4 = 1'b1;
      if (is_wen)
         st_d.wel = 1'b1;
      if (is_ven)
         st_d.vol_act = 1'b1;
      if (is_wsr && (st_q.wel || st_q.vol_act)) begin
         st_d.sr  = arg8;
         st_d.wel = 1'b0;
      end
      if (is_wcf && st_q.wel) begin
         st_d.quad = arg8[QUAD_BIT];
         st_d.wel  = 1'b0;
      end
      if (is_rst || hw_rst) begin
         st_d.addr4   = 1'b0;
         st_d.wel     = 1'b0;
         st_d.vol_act = 1'b0;
         st_d.quad    = 1'b0;
         st_d.sr      = nv_sr_q;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_q      <= '{addr4:1'b0, wel:1'b0, vol_act:1'b0, quad:1'b0, sr:SR_RESET};
         nv_sr_q   <= SR_RESET;
         rst_arm_q <= 1'b0;
         cf_q      <= 48'h0;
         cb_q      <= 6'd0;
      end else if (en_i) begin
         st_q <= st_d;
         if (is_wsr && st_q.wel && !st_q.vol_act)
            nv_sr_q <= arg8;
         if (fr_ev)
            rst_arm_q <= is_ren;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         stat_o    <= '0;
         dword16_o <= 32'h0;
         dq_o      <= 4'h0;
         dq_oe_o   <= 4'h0;
      end else if (en_i) begin
         stat_o    <= st_q;
         dword16_o <= DWORD16;
         dq_o      <= {2'b00, rd_sh_q[7], 1'b0};
         dq_oe_o   <= 4'b0010;
      end
   end
   ////////////////////////////////////////////////////////////////
   a_en4_sets: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && is_en4 && !hw_rst |=> st_q.addr4) else $error("b7 missed");
   a_rst_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && is_rst |=> !st_q.addr4 && !st_q.wel) else $error("reset kept state");
   a_hw_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && hw_rst |=> !st_q.addr4) else $error("hw reset ignored");
   a_sr_guard: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && !st_q.wel && !st_q.vol_act && !hw_rst && !is_rst |=> $stable(st_q.sr))
      else $error("sr written unguarded");
   a_ven_act: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && is_ven && !hw_rst && !is_rst |=> st_q.vol_act) else $error("50h missed");
   sequence s_rst_unarmed;
      en_i && fr_ev && op_hit(op, fbits_q, CMD_RST) && !rst_arm_q && !hw_rst;
   endsequence
   a_rst_refused: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      s_rst_unarmed
      |=> $stable(st_q.addr4) && $stable(st_q.sr))
      else $error("99 without 66 acted");
   a_dword_val: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i |=> dword16_o == 32'ha1f8_50f0) else $error("dword16 wrong");
   a_stat_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i |=> stat_o.quad == $past(st_q.quad)) else $error("quad lag");

   sequence s_rst_enable;
      en_i && is_ren;
   endsequence
   a_arm_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      s_rst_enable
      |=> rst_arm_q)
      else $error("66h did not arm");

   a_wen_sets: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && is_wen && !hw_rst
      |=> st_q.wel)
      else $error("06h missed");

   a_nv_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && !st_q.wel
      |=> $stable(nv_sr_q))
      else $error("nv status written unguarded");

   a_ven_nv: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && is_ven
      |=> $stable(nv_sr_q))
      else $error("50h touched nv status");

   a_hw_sr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && hw_rst
      |=> st_q.sr == $past(nv_sr_q))
      else $error("status not restored from nv copy");

   a_en4_nowel: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && is_en4 && !hw_rst
      |=> $stable(st_q.wel))
      else $error("b7h used write enable");

   a_cfg_guard: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && !st_q.wel && !hw_rst && !is_rst
      |=> $stable(st_q.quad))
      else $error("config written unguarded");

   a_quad_rst: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && (is_rst || hw_rst)
      |=> !st_q.quad && !st_q.vol_act)
      else $error("reset kept volatile state");

   a_ev_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && fr_ev
      |=> !fr_ev)
      else $error("frame event longer than one clock");

   a_oe_fixed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i
      |=> dq_oe_o == 4'b0010)
      else $error("output enable wrong");
endmodule
`default_nettype wire

//--- famr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module famr_host_model (
   output logic       sck_o,
   output logic       cs_n_o,
   output logic [3:0] dq_o
);
   // link clock stands still between frames
   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      dq_o   = 4'h0;
   end
   ////////////////////////////////////////////////////////////////
   // msb first, one or four lanes, 64 ns link period
   task automatic frame(input logic [63:0] d, input int n, input bit q);
      int i;
      cs_n_o = 1'b0;
      for (i = n - 1; i >= 0; i = i - (q ? 4 : 1)) begin
         dq_o = q ? d[i -: 4] : {~dq_o[3:1], d[i]};
         #16 sck_o = 1'b1;
         #32 sck_o = 1'b0;
         #16;
      end
      #8 cs_n_o = 1'b1;
      // released lines do not keep the last value
      dq_o = ~dq_o;
      #100;
   endtask
endmodule
`default_nettype wire

//--- test_flash_addr_mode_reset_srwe.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_addr_mode_reset_srwe;
   import famr_pkg::*;
   logic       clk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic       en_i = 1'b1;
   logic       hw_reset_n_i = 1'b1;
   wire logic  sck, cs_n;
   wire logic [3:0] dq;
   logic [3:0] dq_o, dq_oe_o;
   logic [31:0] dword16_o;
   famr_stat_s stat_o;
   int         err_count = 0;
   int         total_checks = 0;
   always #5 clk_i = ~clk_i;
   famr_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .dq_o(dq));
   famr_core u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(en_i), .sck_i(sck),
      .cs_n_i(cs_n), .dq_i(dq), .hw_reset_n_i(hw_reset_n_i), .dq_o(dq_o),
      .dq_oe_o(dq_oe_o), .dword16_o(dword16_o), .stat_o(stat_o));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // gap covers the answer delay and frame spacing
   task automatic cmd(input logic [63:0] d, input int n, input bit q = 1'b0);
      u_host.frame(d, n, q);
      repeat (10) @(negedge clk_i);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // whole run is about 16 us
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      check("dword16", {8'b10100001, 10'b11_1110_0001, 6'b010000, 1'b1, 7'b1110000},
            dword16_o);
      check("dq_oe", 4'b0010, dq_oe_o);
      check("dq idle", 4'h0, dq_o);
      cmd(8'hb7, 8);
      check("addr4", 1, stat_o.addr4);
      cmd(8'h66, 8);
      cmd(8'h06, 8);
      cmd(8'h99, 8);
      check("addr4", 1, stat_o.addr4);
      cmd(8'h66, 8);
      cmd(8'h99, 8);
      check("addr4", 0, stat_o.addr4);
      check("wel", 0, stat_o.wel);
      cmd(16'h01a5, 16);
      check("sr", 8'h00, stat_o.sr);
      cmd(8'h06, 8);
      cmd(16'h013c, 16);
      check("sr", 8'h3c, stat_o.sr);
      cmd(8'h50, 8);
      cmd(16'h01c3, 16);
      check("vol_act", 1, stat_o.vol_act);
      check("sr", 8'hc3, stat_o.sr);
      cmd(8'hb7, 8);
      hw_reset_n_i = 1'b0;
      repeat (3) @(negedge clk_i);
      hw_reset_n_i = 1'b1;
      repeat (10) @(negedge clk_i);
      check("addr4", 0, stat_o.addr4);
      check("sr", 8'h3c, stat_o.sr);
      cmd(8'h06, 8);
      cmd(40'h7180000340, 40);
      check("quad", 1, stat_o.quad);
      cmd(8'hb7, 8, 1'b1);
      check("addr4", 1, stat_o.addr4);
      cmd(32'hffffffff, 32, 1'b1);
      check("addr4", 1, stat_o.addr4);
      cmd(8'h66, 8, 1'b1);
      cmd(8'h99, 8, 1'b1);
      check("addr4", 0, stat_o.addr4);
      complete_run();
   end
endmodule
`default_nettype wire
